//--- hdl/mpio_defs.svh
// Purpose: constants for the multi-port I/O block
// Assumes: register index = printed offset, byte address = 4 * index
// Notes: Function list below
// Function
// - direction bit one drives, zero listens
// - reset clears every direction register
// - port zero data C0, direction C1
// - port two data C4, direction C5
// - port zero pull-ups per bit when input
// - port two pull-ups per bit when input
// - alternate select resets zero, one selects
// - buzzer and interrupt selects override direction
// - port zero pin alternate function map
// - port two pin alternate function map
// - port three output, display outputs 24-31
// - port four output, display outputs 32-39
// - port five drives the ones of its latch, releases the zeros
// - port five resets to input, display 40-47
// - single-bit and whole-byte access on ports
// - reset leaves ports zero and two input
`ifndef MPIO_DEFS_SVH
`define MPIO_DEFS_SVH
`define MPIO_IDX_P0 8'hC0
`define MPIO_IDX_P0DIR 8'hC1
`define MPIO_IDX_P2 8'hC4
`define MPIO_IDX_P2DIR 8'hC5
`define MPIO_IDX_P3 8'hC6
`define MPIO_IDX_P4 8'hC8
`define MPIO_IDX_P5 8'hCA
`define MPIO_IDX_ALT 8'hF4
`define MPIO_IDX_PU0 8'hFC
`define MPIO_IDX_PU2 8'hFE
`define MPIO_IDX_DSEL 8'h20
`define MPIO_IDX_BITOP 8'h21
`define MPIO_RST_BYTE 8'h00
`define MPIO_ALT_INT0 0
`define MPIO_ALT_INT1 1
`define MPIO_ALT_BUZ 2
`define MPIO_PIN_BUZ 7
`define MPIO_PIN_TI 2
`define MPIO_RESP_OK 2'h0
`define MPIO_RESP_ERR 2'h2
`endif

//--- hdl/mpio_pkg.sv
// Purpose: types for the multi-port I/O block
// Assumes: AXI4-Lite with 10-bit byte address
// Notes: whole block state is one packed struct
package mpio_pkg;
  typedef struct packed {
    logic awvalid; logic [9:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [9:0] araddr;
    logic rready;
  } mpio_axi_m2s_s;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } mpio_axi_s2m_s;
  typedef struct packed {
    logic en; logic clk_o; logic clk_oe; logic dout;
  } mpio_ser_s;
  typedef struct packed {
    logic [7:0] p0_lat, p0_dir, p2_lat, p2_dir, p3_lat, p4_lat, p5_lat;
    logic [7:0] alt, pu0, pu2, dsel;
    logic [7:0] p0_s1, p0_s2, p2_s1, p2_s2, p5_s1, p5_s2;
    logic [7:0] p0_o, p0_oe, p0_pu, p2_o, p2_oe, p2_pu, p3_o, p4_o;
    logic [7:0] p5_o, p5_oe;
    logic [1:0] ext_int; logic ti;
    logic ser_a_din, ser_a_clk_in, ser_b_clk_in;
    logic aw_have, w_have; logic [9:0] awaddr; logic [31:0] wdata;
    logic [3:0] wstrb;
    mpio_axi_s2m_s axi;
  } mpio_state_s;
endpackage

//--- hdl/mpio_top.sv
// Purpose: five-port general purpose I/O block with AXI4-Lite registers
// Assumes: pins asynchronous, peripheral signals on clk_sys
// Notes: pin outputs change on the same clock edge as the register written
`timescale 1ns/1ns
`include "mpio_defs.svh"
module mpio_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire mpio_pkg::mpio_axi_m2s_s axi_m,
  output mpio_pkg::mpio_axi_s2m_s axi_s,
  input wire logic [7:0] port_zero_in,
  output logic [7:0] port_zero_out,
  output logic [7:0] port_zero_oe,
  output logic [7:0] port_zero_pullup_en,
  input wire logic [7:0] port_two_in,
  output logic [7:0] port_two_out,
  output logic [7:0] port_two_oe,
  output logic [7:0] port_two_pullup_en,
  output logic [7:0] port_three_out,
  output logic [7:0] port_four_out,
  input wire logic [7:0] port_five_in,
  output logic [7:0] port_five_out,
  output logic [7:0] port_five_oe,
  input wire logic [23:0] display_driver_in,
  input wire logic buzzer_drive,
  input wire mpio_pkg::mpio_ser_s serial_a,
  input wire mpio_pkg::mpio_ser_s serial_b,
  output logic [1:0] ext_interrupt_in,
  output logic remote_timer_input,
  output logic serial_a_data_in,
  output logic serial_a_clock_in,
  output logic serial_b_clock_in
);
  import mpio_pkg::*;

  mpio_state_s r, n;
  logic [7:0] wr_idx, rd_idx;
  logic [2:0] bit_sel, bit_port;
  logic bit_val;
  logic [7:0] p0_rd, p2_rd;

  // decode helpers; index is byte address divided by four
  assign wr_idx = r.awaddr[9:2];
  assign rd_idx = axi_m.araddr[9:2];
  assign bit_sel = r.wdata[2:0];
  assign bit_port = r.wdata[6:4];
  assign bit_val = r.wdata[8];
  // mixed read: pin level where listening, latch where driving
  assign p0_rd = (r.p0_s2 & ~r.p0_oe) | (r.p0_lat & r.p0_oe);
  assign p2_rd = (r.p2_s2 & ~r.p2_oe) | (r.p2_lat & r.p2_oe);

  // next state of the whole block
  always_comb begin
    n = r;
    // pin synchronisers; first stage feeds only the second
    n.p0_s1 = port_zero_in;
    n.p0_s2 = r.p0_s1;
    n.p2_s1 = port_two_in;
    n.p2_s2 = r.p2_s1;
    n.p5_s1 = port_five_in;
    n.p5_s2 = r.p5_s1;
    // write address and data channels, taken in either order
    if (axi_m.awvalid && r.axi.awready) begin
      n.aw_have = 1'b1;
      n.awaddr = axi_m.awaddr;
      n.axi.awready = 1'b0;
    end
    if (axi_m.wvalid && r.axi.wready) begin
      n.w_have = 1'b1;
      n.wdata = axi_m.wdata;
      n.wstrb = axi_m.wstrb;
      n.axi.wready = 1'b0;
    end
    // perform the write once both halves are held
    if (r.aw_have && r.w_have && !r.axi.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.axi.bvalid = 1'b1;
      n.axi.bresp = `MPIO_RESP_OK;
      case (wr_idx)
        `MPIO_IDX_P0: if (r.wstrb[0]) n.p0_lat = r.wdata[7:0];
        `MPIO_IDX_P0DIR: if (r.wstrb[0]) n.p0_dir = r.wdata[7:0];
        `MPIO_IDX_P2: if (r.wstrb[0]) n.p2_lat = r.wdata[7:0];
        `MPIO_IDX_P2DIR: if (r.wstrb[0]) n.p2_dir = r.wdata[7:0];
        `MPIO_IDX_P3: if (r.wstrb[0]) n.p3_lat = r.wdata[7:0];
        `MPIO_IDX_P4: if (r.wstrb[0]) n.p4_lat = r.wdata[7:0];
        `MPIO_IDX_P5: if (r.wstrb[0]) n.p5_lat = r.wdata[7:0];
        `MPIO_IDX_ALT: if (r.wstrb[0]) n.alt = r.wdata[7:0];
        `MPIO_IDX_PU0: if (r.wstrb[0]) n.pu0 = r.wdata[7:0];
        `MPIO_IDX_PU2: if (r.wstrb[0]) n.pu2 = r.wdata[7:0];
        `MPIO_IDX_DSEL: if (r.wstrb[0]) n.dsel = r.wdata[7:0];
        `MPIO_IDX_BITOP: begin
          // one pin changes, the other seven keep their latch
          if (r.wstrb[1:0] == 2'h3) begin
            case (bit_port)
              3'h0: n.p0_lat[bit_sel] = bit_val;
              3'h1: n.p2_lat[bit_sel] = bit_val;
              3'h2: n.p3_lat[bit_sel] = bit_val;
              3'h3: n.p4_lat[bit_sel] = bit_val;
              3'h4: n.p5_lat[bit_sel] = bit_val;
              default: n.axi.bresp = `MPIO_RESP_ERR;
            endcase
          end
        end
        default: n.axi.bresp = `MPIO_RESP_ERR;
      endcase
    end
    // response taken; reopen both write channels
    if (r.axi.bvalid && axi_m.bready) begin
      n.axi.bvalid = 1'b0;
      n.axi.awready = 1'b1;
      n.axi.wready = 1'b1;
    end
    // read: answer one cycle after the address is taken
    if (axi_m.arvalid && r.axi.arready) begin
      n.axi.arready = 1'b0;
      n.axi.rvalid = 1'b1;
      n.axi.rresp = `MPIO_RESP_OK;
      n.axi.rdata = 32'h0000_0000;
      case (rd_idx)
        `MPIO_IDX_P0: n.axi.rdata[7:0] = p0_rd;
        `MPIO_IDX_P0DIR: n.axi.rdata[7:0] = r.p0_dir;
        `MPIO_IDX_P2: n.axi.rdata[7:0] = p2_rd;
        `MPIO_IDX_P2DIR: n.axi.rdata[7:0] = r.p2_dir;
        `MPIO_IDX_P3: n.axi.rdata[7:0] = r.p3_lat;
        `MPIO_IDX_P4: n.axi.rdata[7:0] = r.p4_lat;
        // port five reads the pin; latch must be zero to listen
        `MPIO_IDX_P5: n.axi.rdata[7:0] = r.p5_s2;
        `MPIO_IDX_ALT: n.axi.rdata[7:0] = r.alt;
        `MPIO_IDX_PU0: n.axi.rdata[7:0] = r.pu0;
        `MPIO_IDX_PU2: n.axi.rdata[7:0] = r.pu2;
        `MPIO_IDX_DSEL: n.axi.rdata[7:0] = r.dsel;
        `MPIO_IDX_BITOP: n.axi.rdata = 32'h0000_0000;
        default: n.axi.rresp = `MPIO_RESP_ERR;
      endcase
    end
    if (r.axi.rvalid && axi_m.rready) begin
      n.axi.rvalid = 1'b0;
      n.axi.arready = 1'b1;
    end
    // port zero drivers from the next register values
    n.p0_oe = n.p0_dir;
    n.p0_o = n.p0_lat;
    // interrupt pins listen whatever the direction bit says
    if (n.alt[`MPIO_ALT_INT0]) n.p0_oe[0] = 1'b0;
    if (n.alt[`MPIO_ALT_INT1]) n.p0_oe[1] = 1'b0;
    if (n.alt[`MPIO_ALT_BUZ]) begin
      n.p0_oe[`MPIO_PIN_BUZ] = 1'b1;
      n.p0_o[`MPIO_PIN_BUZ] = buzzer_drive;
    end
    // pull-ups only on pins that are not driven
    n.p0_pu = n.pu0 & ~n.p0_oe;
    // port two: serial units take their pins while enabled
    n.p2_oe = n.p2_dir;
    n.p2_o = n.p2_lat;
    if (serial_b.en) begin
      n.p2_oe[0] = serial_b.clk_oe;
      n.p2_o[0] = serial_b.clk_o;
      n.p2_oe[1] = 1'b1;
      n.p2_o[1] = serial_b.dout;
    end
    if (serial_a.en) begin
      n.p2_oe[5] = 1'b1;
      n.p2_o[5] = serial_a.dout;
      n.p2_oe[6] = 1'b0;
      n.p2_oe[7] = serial_a.clk_oe;
      n.p2_o[7] = serial_a.clk_o;
    end
    n.p2_pu = n.pu2 & ~n.p2_oe;
    // high-voltage ports: latch or display driver
    n.p3_o = n.dsel[0] ? display_driver_in[7:0] : n.p3_lat;
    n.p4_o = n.dsel[1] ? display_driver_in[15:8] : n.p4_lat;
    // port five: display driver on all pins, else drives a one, releases a zero so the pin can be read
    if (n.dsel[2]) begin
      n.p5_o = display_driver_in[23:16];
      n.p5_oe = 8'hFF;
    end else begin
      n.p5_o = n.p5_lat;
      n.p5_oe = n.p5_lat;
    end
    // alternate inputs toward the peripherals, after synchronising
    n.ext_int = r.p0_s2[1:0] & r.alt[`MPIO_ALT_INT1:`MPIO_ALT_INT0];
    n.ti = r.p0_s2[`MPIO_PIN_TI];
    n.ser_a_din = r.p2_s2[6];
    n.ser_a_clk_in = r.p2_s2[7];
    n.ser_b_clk_in = r.p2_s2[0];
  end

  // single state register; reset leaves every port zero, two and five pin listening
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.alt <= `MPIO_RST_BYTE;
      r.p0_dir <= `MPIO_RST_BYTE;
      r.p2_dir <= `MPIO_RST_BYTE;
      r.axi.awready <= 1'b1;
      r.axi.wready <= 1'b1;
      r.axi.arready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign axi_s = r.axi;
  assign port_zero_out = r.p0_o;
  assign port_zero_oe = r.p0_oe;
  assign port_zero_pullup_en = r.p0_pu;
  assign port_two_out = r.p2_o;
  assign port_two_oe = r.p2_oe;
  assign port_two_pullup_en = r.p2_pu;
  assign port_three_out = r.p3_o;
  assign port_four_out = r.p4_o;
  assign port_five_out = r.p5_o;
  assign port_five_oe = r.p5_oe;
  assign ext_interrupt_in = r.ext_int;
  assign remote_timer_input = r.ti;
  assign serial_a_data_in = r.ser_a_din;
  assign serial_a_clock_in = r.ser_a_clk_in;
  assign serial_b_clock_in = r.ser_b_clk_in;

  // helper: high in the first cycle after reset release
  logic first_r;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) first_r <= 1'b1;
    else first_r <= 1'b0;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // write performed: both halves held, no response pending
  sequence s_wr_both;
    r.aw_have && r.w_have && !r.axi.bvalid;
  endsequence

  // read of the port zero data register taken this cycle
  sequence s_rd_p0;
    axi_m.arvalid && r.axi.arready && rd_idx == `MPIO_IDX_P0;
  endsequence

  // single-bit write aimed at the port zero latch
  sequence s_bit_p0;
    s_wr_both ##0 (wr_idx == `MPIO_IDX_BITOP && r.wstrb[1:0] == 2'h3 &&
    bit_port == 3'h0);
  endsequence

  // buzzer selected and the select register steady
  sequence s_buz_steady;
    r.alt[`MPIO_ALT_BUZ] && $stable(r.alt);
  endsequence

  // serial unit b owns its clock and data pins
  sequence s_ser_b_on;
    serial_b.en;
  endsequence

  // port zero and five pins listen and the port two direction register is clear right after reset
  chk_reset_inputs: assert property (
    first_r |-> (r.p0_oe == 8'h00 && r.p2_dir == 8'h00 && r.p5_oe == 8'h00))
    else $error("ports not in input mode after reset");

  // direction registers and the alternate select register come out of reset cleared
  chk_reset_regs: assert property (
    first_r |-> (r.p0_dir == `MPIO_RST_BYTE && r.p2_dir == `MPIO_RST_BYTE &&
    r.alt == `MPIO_RST_BYTE))
    else $error("control register not cleared by reset");

  // no drive and no pull-up on port two before software asks
  chk_reset_p2: assert property (
    first_r |-> (r.p2_oe == 8'h00 && r.p2_pu == 8'h00))
    else $error("port two not listening after reset");

  // direction bit alone decides the timer and analog pins
  chk_dir_drive: assert property (
    r.p0_oe[6:2] == r.p0_dir[6:2])
    else $error("port zero drive does not follow direction");

  // analog pins of port two are never taken by a serial unit
  chk_dir_two: assert property (
    r.p2_oe[4:2] == r.p2_dir[4:2])
    else $error("port two drive does not follow direction");

  // pull-up only where enabled and the pin is not driven
  chk_pullup_in: assert property (
    r.p0_pu == (r.pu0 & ~r.p0_oe))
    else $error("pull-up on a driven pin or missing");

  // same for port two, serial overrides included
  chk_pullup_two: assert property (
    r.p2_pu == (r.pu2 & ~r.p2_oe))
    else $error("port two pull-up on a driven pin or missing");

  // buzzer wins over the direction bit
  chk_buz_force: assert property (
    s_buz_steady |-> r.p0_oe[7] &&
    r.p0_o[7] == $past(buzzer_drive))
    else $error("buzzer select did not drive pin");

  // interrupt zero pin listens whatever the direction bit says
  chk_int_listen: assert property (
    r.alt[`MPIO_ALT_INT0] |=> !r.p0_oe[0] || !$past(r.alt[0], 1) ||
    !r.alt[0])
    else $error("interrupt pin driven while selected");

  // interrupt one pin likewise
  chk_int_one: assert property (
    r.alt[`MPIO_ALT_INT1] |=> !r.p0_oe[1] || !r.alt[1])
    else $error("interrupt one pin driven while selected");

  // interrupt requests are the synchronised pins, gated by select
  chk_ext_int: assert property (
    r.ext_int == ($past(r.p0_s2[1:0]) & $past(r.alt[1:0])))
    else $error("interrupt request not from its pin");

  // timer input follows its synchronised pin one clock later
  chk_ti_follow: assert property (
    r.ti == $past(r.p0_s2[`MPIO_PIN_TI]))
    else $error("timer input not from its pin");

  // serial unit b drives its data pin while enabled
  chk_ser_b_pins: assert property (
    s_ser_b_on |=> r.p2_oe[1] && r.p2_o[1] == $past(serial_b.dout))
    else $error("serial b data pin not driven");

  // serial unit a drives data out and listens on data in
  chk_ser_a_pins: assert property (
    serial_a.en |=> r.p2_oe[5] && !r.p2_oe[6])
    else $error("serial a pins not in their roles");

  // display outputs take port three while selected
  chk_disp_three: assert property (
    r.dsel[0] && $stable(r.dsel) |-> r.p3_o == $past(display_driver_in[7:0]))
    else $error("display data missing on port three");

  // port three shows its latch otherwise
  chk_p3_latch: assert property (
    !r.dsel[0] |-> r.p3_o == r.p3_lat)
    else $error("port three not showing its latch");

  // display outputs take port four while selected
  chk_disp_four: assert property (
    r.dsel[1] && $stable(r.dsel) |-> r.p4_o == $past(display_driver_in[15:8]))
    else $error("display data missing on port four");

  // port four shows its latch otherwise
  chk_p4_latch: assert property (
    !r.dsel[1] |-> r.p4_o == r.p4_lat)
    else $error("port four not showing its latch");

  // port five drives ones of its latch, releases the zeros
  chk_p5_latch: assert property (
    !r.dsel[2] |-> r.p5_oe == r.p5_lat && r.p5_o == r.p5_lat)
    else $error("port five not driving its latch");

  // display outputs drive every port five pin while selected
  chk_disp_five: assert property (
    r.dsel[2] && $stable(r.dsel) |-> r.p5_oe == 8'hFF &&
    r.p5_o == $past(display_driver_in[23:16]))
    else $error("display data missing on port five");

  // a write answers next cycle; a port zero direction write lands in that register
  chk_wr_resp: assert property (
    s_wr_both |=> r.axi.bvalid ##0 (r.awaddr[9:2] != `MPIO_IDX_P0DIR ||
    !r.wstrb[0] || r.p0_dir == r.wdata[7:0] || r.axi.bresp != 2'h0))
    else $error("write response or direction update missing");

  // port zero read mixes pin and latch by direction
  chk_read_mix: assert property (
    s_rd_p0 |=> r.axi.rvalid && r.axi.rdata[7:0] == $past(p0_rd))
    else $error("port zero read not pin or latch mix");

  // port five read returns the synchronised pin level
  chk_p5_read: assert property (
    axi_m.arvalid && r.axi.arready && rd_idx == `MPIO_IDX_P5 |=>
    r.axi.rdata[7:0] == $past(r.p5_s2))
    else $error("port five read not the pin level");

  // the addressed bit takes the written value
  chk_bit_one: assert property (
    s_bit_p0 |=> r.p0_lat[$past(bit_sel)] == $past(bit_val))
    else $error("single-bit write missed its bit");

  // the other seven bits keep their latch
  chk_bit_keep: assert property (
    s_bit_p0 |=> ((r.p0_lat ^ $past(r.p0_lat)) &
    ~(8'h01 << $past(bit_sel))) == 8'h00)
    else $error("single-bit write disturbed other bits");
endmodule

//--- tb/mpio_pin_model.sv
// Purpose: far-side model of one 8-bit port's pins
// Assumes: far side drives a pin only where ext_en is set
// Notes: an open pin with no pull-up toggles every cycle
`timescale 1ns/1ns
module mpio_pin_model (
  input wire logic clk_sys,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pu,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_lvl
);
  logic [7:0] flt_r = 8'h5A;
  // a stale level must never pass for a read of an open pin
  always @(posedge clk_sys) begin
    flt_r <= ~flt_r;
  end
  // block drive first, then far side, then pull-up, else floating
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pu | flt_r));
endmodule

//--- tb/multi_port_io_block_bench.sv
// Purpose: self-checking bench of the multi-port I/O block
// Assumes: byte address is four times the register index
// Notes: serial inputs idle except in t_ser; pins come from pin models
`timescale 1ns/1ns
module multi_port_io_block_bench;
  import mpio_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  mpio_axi_m2s_s m = '0;
  mpio_axi_s2m_s s;
  logic [7:0] p0i, p0o, p0e, p0u, p2i, p2o, p2e, p2u, p3, p4, p5i, p5o, p5e;
  logic [7:0] d0v = 8'h00, d0e = 8'h00, d2v = 8'h00, d2e = 8'h00;
  logic [7:0] d5v = 8'h00, d5e = 8'h00;
  logic [23:0] disp = 24'h123456;
  logic buz = 1'b1;
  logic [1:0] eint;
  logic ti, sadi, sack, sbck;
  mpio_ser_s sa = '0;
  mpio_ser_s sb = '0;
  logic [31:0] rdv;
  logic [1:0] rsp;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  always #4 clk_sys = ~clk_sys;
  mpio_top i_mpio_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .axi_m(m),
    .axi_s(s), .port_zero_in(p0i), .port_zero_out(p0o), .port_zero_oe(p0e),
    .port_zero_pullup_en(p0u), .port_two_in(p2i), .port_two_out(p2o),
    .port_two_oe(p2e), .port_two_pullup_en(p2u), .port_three_out(p3),
    .port_four_out(p4), .port_five_in(p5i), .port_five_out(p5o),
    .port_five_oe(p5e), .display_driver_in(disp), .buzzer_drive(buz),
    .serial_a(sa), .serial_b(sb), .ext_interrupt_in(eint),
    .remote_timer_input(ti), .serial_a_data_in(sadi),
    .serial_a_clock_in(sack), .serial_b_clock_in(sbck));
  mpio_pin_model i_pin0 (.clk_sys(clk_sys), .pin_out(p0o), .pin_oe(p0e),
    .pin_pu(p0u), .ext_val(d0v), .ext_en(d0e), .pin_lvl(p0i));
  mpio_pin_model i_pin2 (.clk_sys(clk_sys), .pin_out(p2o), .pin_oe(p2e),
    .pin_pu(p2u), .ext_val(d2v), .ext_en(d2e), .pin_lvl(p2i));
  mpio_pin_model i_pin5 (.clk_sys(clk_sys), .pin_out(p5o), .pin_oe(p5e),
    .pin_pu(8'h00), .ext_val(d5v), .ext_en(d5e), .pin_lvl(p5i));
  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // ready is looked at mid-cycle, so the take edge is never raced
  task automatic wr(input logic [7:0] i, input logic [31:0] d,
      input logic [3:0] st = 4'hF);
    logic b, aw, w;
    b = 1'b0;
    @(posedge clk_sys);
    m.awaddr <= {i, 2'h0};
    m.wdata <= d;
    m.wstrb <= st;
    m.awvalid <= 1'b1;
    m.wvalid <= 1'b1;
    m.bready <= 1'b1;
    while (!b) begin
      @(negedge clk_sys);
      b = s.bvalid;
      rsp = s.bresp;
      aw = s.awready;
      w = s.wready;
      @(posedge clk_sys);
      if (aw) m.awvalid <= 1'b0;
      if (w) m.wvalid <= 1'b0;
    end
    m.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i);
    logic b, a;
    b = 1'b0;
    @(posedge clk_sys);
    m.araddr <= {i, 2'h0};
    m.arvalid <= 1'b1;
    m.rready <= 1'b1;
    while (!b) begin
      @(negedge clk_sys);
      b = s.rvalid;
      rdv = s.rdata;
      rsp = s.rresp;
      a = s.arready;
      @(posedge clk_sys);
      if (a) m.arvalid <= 1'b0;
    end
    m.rready <= 1'b0;
  endtask
  // pin levels pass a two-flop synchroniser before reads see them
  task automatic settle;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic t_reset;
    rd(8'hC1); chk("dir0", 32'h0, rdv);
    rd(8'hC5); chk("dir2", 32'h0, rdv);
    rd(8'hF4); chk("alt", 32'h0, rdv);
    chk("oe0", 8'h00, p0e);
    chk("oe2", 8'h00, p2e);
    chk("oe5", 8'h00, p5e);
    $display("test reset done");
  endtask
  task automatic t_dir;
    wr(8'hC1, 32'h55);
    wr(8'hC0, 32'hFF);
    chk("oe0", 8'h55, p0e);
    chk("out0", 8'h55, p0o & p0e);
    d0v <= 8'h0A;
    d0e <= 8'hFF;
    settle;
    chk("ti", 1'b1, ti);
    rd(8'hC0); chk("rd0", 32'h5F, rdv);
    wr(8'hC5, 32'hAA);
    wr(8'hC4, 32'h0F);
    chk("oe2", 8'hAA, p2e);
    chk("out2", 8'h0A, p2o & p2e);
    d2v <= 8'hF0;
    d2e <= 8'hFF;
    settle;
    rd(8'hC4); chk("rd2", 32'h5A, rdv);
    $display("test direction done");
  endtask
  task automatic t_pull;
    wr(8'hFC, 32'hFF); chk("pu0", 8'hAA, p0u);
    wr(8'hFE, 32'hFF); chk("pu2", 8'h55, p2u);
    $display("test pullup done");
  endtask
  task automatic t_alt;
    d0v <= 8'h03;
    wr(8'hF4, 32'h07);
    settle;
    chk("int", 2'h3, eint);
    chk("intoe", 2'h0, p0e[1:0]);
    chk("buzoe", 1'b1, p0e[7]);
    chk("buzout", 1'b1, p0o[7]);
    buz <= 1'b0;
    settle;
    chk("buzlow", 1'b0, p0o[7]);
    wr(8'hF4, 32'h00);
    settle;
    chk("intoff", 2'h0, eint);
    $display("test alternate done");
  endtask
  task automatic t_out;
    wr(8'hC6, 32'hA5); chk("p3", 8'hA5, p3);
    wr(8'hC8, 32'h3C); chk("p4", 8'h3C, p4);
    wr(8'h20, 32'h07);
    settle;
    chk("p3disp", 8'h56, p3);
    chk("p4disp", 8'h34, p4);
    chk("p5disp", 8'h12, p5o & p5e);
    chk("p5dispoe", 8'hFF, p5e);
    wr(8'h20, 32'h00);
    $display("test output ports done");
  endtask
  task automatic t_p5;
    wr(8'hCA, 32'h81); chk("out5", 8'h81, p5o & p5e);
    wr(8'hCA, 32'h00);
    d5v <= 8'h5A;
    d5e <= 8'hFF;
    settle;
    rd(8'hCA); chk("rd5", 32'h5A, rdv);
    $display("test port five done");
  endtask
  task automatic t_bit;
    wr(8'h21, 32'h002, 4'h3); chk("bit0", 8'h51, p0o & p0e);
    rd(8'hC0); chk("rd0bit", 32'h53, rdv);
    wr(8'h21, 32'h020, 4'h3); chk("bit3", 8'hA4, p3);
    $display("test bit access done");
  endtask
  task automatic t_bad;
    rd(8'h10); chk("rresp", 2'h2, rsp);
    chk("rdata", 32'h0, rdv);
    wr(8'h10, 32'hFF); chk("bresp", 2'h2, rsp);
    rd(8'hC6); chk("p3keep", 32'hA4, rdv);
    $display("test unmapped done");
  endtask
  // serial units take their port two pins over the direction bits
  task automatic t_ser;
    sb <= '{en: 1'b1, clk_o: 1'b1, clk_oe: 1'b1, dout: 1'b0};
    sa <= '{en: 1'b1, clk_o: 1'b0, clk_oe: 1'b0, dout: 1'b1};
    settle;
    settle;
    chk("oe2ser", 8'h2B, p2e);
    chk("out2ser", 8'h29, p2o & p2e);
    chk("pu2ser", 8'hD4, p2u);
    chk("sadin", 1'b1, sadi);
    chk("saclk", 1'b1, sack);
    chk("sbclk", 1'b1, sbck);
    sa <= '0;
    sb <= '0;
    $display("test serial pins done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // the whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      finish_test;
    end
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset;
    t_dir;
    t_pull;
    t_alt;
    t_out;
    t_p5;
    t_bit;
    t_bad;
    t_ser;
    finish_test;
  end
endmodule
